// File: include/dbw_pkg.sv
package dbw_pkg;

  // ----------------------------------------------------------------
  // register numbers on the processor status port
  // ----------------------------------------------------------------
  localparam logic [7:0]  DBW_REG_CAUSE   = 8'h15;
  localparam logic [7:0]  DBW_REG_DATA    = 8'h16;
  localparam logic [7:0]  DBW_REG_HALT    = 8'h18;
  localparam logic [7:0]  DBW_REG_SCR     = 8'h20;
  localparam logic [7:0]  DBW_REG_IB_ADDR = 8'h30;
  localparam logic [7:0]  DBW_REG_IB_CTRL = 8'h40;
  localparam logic [7:0]  DBW_REG_DW_A    = 8'h50;
  localparam logic [7:0]  DBW_REG_DW_B    = 8'h60;
  localparam logic [7:0]  DBW_REG_DW_CTRL = 8'h70;
  localparam logic [7:0]  DBW_REG_RW_MASK = 8'h80;
  localparam logic [7:0]  DBW_REG_RW_VAL  = 8'h90;
  localparam logic [7:0]  DBW_REG_RW_CTRL = 8'h9C;
  // scratch words seen from the tile configuration port
  localparam logic [7:0]  DBW_CFG_SCR     = 8'h20;

  // ----------------------------------------------------------------
  // field positions and write masks
  // ----------------------------------------------------------------
  localparam int          DBW_CAUSE_LSB   = 0;
  localparam int          DBW_THR_LSB     = 8;
  localparam int          DBW_IDX_LSB     = 16;
  localparam int          DBW_EN_BIT      = 0;
  localparam int          DBW_SEL_BIT     = 1;
  localparam int          DBW_LOAD_BIT    = 2;
  localparam int          DBW_TEN_LSB     = 16;
  localparam logic [31:0] DBW_IB_WMASK    = 32'h00FF0003;
  localparam logic [31:0] DBW_DW_WMASK    = 32'h00FF0007;
  localparam logic [31:0] DBW_RW_WMASK    = 32'h00FF0003;
  localparam logic [31:0] DBW_RST_WORD    = 32'h00000000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DBW_CAUSE_NONE   = 3'h0,
    DBW_CAUSE_HOST   = 3'h1,
    DBW_CAUSE_DEBUG_CALL_INSTRUCTION  = 3'h2,
    DBW_CAUSE_IBRK   = 3'h3,
    DBW_CAUSE_DWATCH = 3'h4,
    DBW_CAUSE_RWATCH = 3'h5
  } dbw_cause_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  num;
    logic [31:0] wdata;
  } dbw_req_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  thread;
    logic [31:0] pc;
  } dbw_pc_t;

  typedef struct packed {
    logic        valid;
    logic        is_load;
    logic [2:0]  thread;
    logic [31:0] addr;
  } dbw_mem_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  thread;
    logic [31:0] id;
  } dbw_res_t;

  typedef struct packed {
    dbw_cause_t       cause;
    logic [1:0]       idx;
    logic [7:0]       thr;
    logic [31:0]      data;
    logic [7:0]       halt;
    logic [7:0]       inhibit;
    logic [7:0][31:0] scr;
    logic [3:0][31:0] ib_addr;
    logic [3:0][31:0] ib_ctrl;
    logic [3:0][31:0] dw_a;
    logic [3:0][31:0] dw_b;
    logic [3:0][31:0] dw_ctrl;
    logic [3:0][31:0] rw_mask;
    logic [3:0][31:0] rw_val;
    logic [3:0][31:0] rw_ctrl;
    logic [31:0]      ps_rdata;
    logic [31:0]      cfg_rdata;
    logic             irq;
  } dbw_state_t;

endpackage

// File: src/dbw_unit.sv
`timescale 1ns/1ps

module dbw_unit
  import dbw_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // processor status register port
  input  wire dbw_req_t   i_ps_req,
  output logic [31:0]     o_ps_rdata,
  // tile configuration port
  input  wire dbw_req_t   i_cfg_req,
  output logic [31:0]     o_cfg_rdata,
  // processor mode and debug sources
  input  wire logic       i_in_debug,
  input  wire logic       i_host_req,
  input  wire logic       i_debug_call_instruction,
  input  wire logic [2:0] i_debug_call_instruction_thread,
  // pipeline observation
  input  wire dbw_pc_t    i_pc,
  input  wire dbw_mem_t   i_mem,
  input  wire dbw_res_t   i_res,
  // to the core
  output logic            o_dbg_irq,
  output logic [7:0]      o_halt_mask,
  output logic [7:0]      o_issue_inhibit
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic in_grp(input logic [7:0] num, input logic [7:0] base);
    return num[7:2] == base[7:2];
  endfunction

  function automatic logic in_scr(input logic [7:0] num, input logic [7:0] base);
    return num[7:3] == base[7:3];
  endfunction

  function automatic logic thr_ok(input logic [31:0] ctrl, input logic [2:0] t);
    logic [7:0] f;
    f = ctrl[DBW_TEN_LSB +: 8];
    return f[t];
  endfunction

  // lowest set bit wins when several units fire together
  function automatic logic [1:0] first_hit(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] rd_ps(input dbw_state_t s, input logic [7:0] num);
    logic [31:0] r;
    logic [1:0]  k;
    r = DBW_RST_WORD;
    k = num[1:0];
    if (num == DBW_REG_CAUSE) begin
      r = {14'h0, s.idx, s.thr, 5'h0, s.cause};
    end else if (num == DBW_REG_DATA) begin
      r = s.data;
    end else if (num == DBW_REG_HALT) begin
      r = {24'h0, s.halt};
    end else if (in_scr(num, DBW_REG_SCR)) begin
      r = s.scr[num[2:0]];
    end else if (in_grp(num, DBW_REG_IB_ADDR)) begin
      r = s.ib_addr[k];
    end else if (in_grp(num, DBW_REG_IB_CTRL)) begin
      r = s.ib_ctrl[k];
    end else if (in_grp(num, DBW_REG_DW_A)) begin
      r = s.dw_a[k];
    end else if (in_grp(num, DBW_REG_DW_B)) begin
      r = s.dw_b[k];
    end else if (in_grp(num, DBW_REG_DW_CTRL)) begin
      r = s.dw_ctrl[k];
    end else if (in_grp(num, DBW_REG_RW_MASK)) begin
      r = s.rw_mask[k];
    end else if (in_grp(num, DBW_REG_RW_VAL)) begin
      r = s.rw_val[k];
    end else if (in_grp(num, DBW_REG_RW_CTRL)) begin
      r = s.rw_ctrl[k];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // match logic
  // ----------------------------------------------------------------
  dbw_state_t s_r;
  dbw_state_t s_nxt;
  logic [3:0] ib_hit;
  logic [3:0] dw_hit;
  logic [3:0] rw_hit;

  for (genvar g = 0; g < 4; g++) begin : g_unit
    logic cond_a;
    logic cond_b;
    logic kind_ok;
    logic res_eq;
    assign cond_a  = i_mem.addr == s_r.dw_a[g];
    assign cond_b  = i_mem.addr == s_r.dw_b[g];
    assign kind_ok = !i_mem.is_load || s_r.dw_ctrl[g][DBW_LOAD_BIT];
    assign res_eq  = (i_res.id & s_r.rw_mask[g]) == (s_r.rw_val[g] & s_r.rw_mask[g]);
    assign ib_hit[g] = i_pc.valid && s_r.ib_ctrl[g][DBW_EN_BIT] &&
                       thr_ok(s_r.ib_ctrl[g], i_pc.thread) &&
                       ((i_pc.pc == s_r.ib_addr[g]) ^ s_r.ib_ctrl[g][DBW_SEL_BIT]);
    assign dw_hit[g] = i_mem.valid && s_r.dw_ctrl[g][DBW_EN_BIT] && kind_ok &&
                       thr_ok(s_r.dw_ctrl[g], i_mem.thread) &&
                       (s_r.dw_ctrl[g][DBW_SEL_BIT] ? (cond_a | cond_b) : (cond_a & cond_b));
    assign rw_hit[g] = i_res.valid && s_r.rw_ctrl[g][DBW_EN_BIT] &&
                       thr_ok(s_r.rw_ctrl[g], i_res.thread) &&
                       (res_eq ^ s_r.rw_ctrl[g][DBW_SEL_BIT]);
  end

  // ----------------------------------------------------------------
  // cause selection
  // ----------------------------------------------------------------
  dbw_cause_t sel_cause;
  logic [1:0] sel_idx;
  logic [7:0] sel_thr;

  always_comb begin
    sel_cause = DBW_CAUSE_NONE;
    sel_idx   = 2'h0;
    sel_thr   = 8'h00;
    if (i_host_req) begin
      sel_cause = DBW_CAUSE_HOST;
    end else if (i_debug_call_instruction) begin
      sel_cause = DBW_CAUSE_DEBUG_CALL_INSTRUCTION;
      sel_thr   = {5'h00, i_debug_call_instruction_thread};
    end else if (|ib_hit) begin
      sel_cause = DBW_CAUSE_IBRK;
      sel_idx   = first_hit(ib_hit);
      sel_thr   = {5'h00, i_pc.thread};
    end else if (|dw_hit) begin
      sel_cause = DBW_CAUSE_DWATCH;
      sel_idx   = first_hit(dw_hit);
      sel_thr   = {5'h00, i_mem.thread};
    end else if (|rw_hit) begin
      sel_cause = DBW_CAUSE_RWATCH;
      sel_idx   = first_hit(rw_hit);
      sel_thr   = {5'h00, i_res.thread};
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] w;
    logic [1:0]  k;
    w     = i_ps_req.wdata;
    k     = i_ps_req.num[1:0];
    s_nxt = s_r;
    s_nxt.irq = 1'b0;
    // configuration port reaches only the scratch words
    if (i_cfg_req.wr && in_scr(i_cfg_req.num, DBW_CFG_SCR)) begin
      s_nxt.scr[i_cfg_req.num[2:0]] = i_cfg_req.wdata;
    end
    // status port write comes later, so it wins a same-word collision
    if (i_ps_req.wr && i_in_debug) begin
      if (i_ps_req.num == DBW_REG_CAUSE) begin
        s_nxt.cause = dbw_cause_t'(w[DBW_CAUSE_LSB +: 3]);
        s_nxt.thr   = w[DBW_THR_LSB +: 8];
        s_nxt.idx   = w[DBW_IDX_LSB +: 2];
      end else if (i_ps_req.num == DBW_REG_DATA) begin
        s_nxt.data = w;
      end else if (i_ps_req.num == DBW_REG_HALT) begin
        s_nxt.halt = w[7:0];
      end else if (in_scr(i_ps_req.num, DBW_REG_SCR)) begin
        s_nxt.scr[i_ps_req.num[2:0]] = w;
      end else if (in_grp(i_ps_req.num, DBW_REG_IB_ADDR)) begin
        s_nxt.ib_addr[k] = w;
      end else if (in_grp(i_ps_req.num, DBW_REG_IB_CTRL)) begin
        s_nxt.ib_ctrl[k] = w & DBW_IB_WMASK;
      end else if (in_grp(i_ps_req.num, DBW_REG_DW_A)) begin
        s_nxt.dw_a[k] = w;
      end else if (in_grp(i_ps_req.num, DBW_REG_DW_B)) begin
        s_nxt.dw_b[k] = w;
      end else if (in_grp(i_ps_req.num, DBW_REG_DW_CTRL)) begin
        s_nxt.dw_ctrl[k] = w & DBW_DW_WMASK;
      end else if (in_grp(i_ps_req.num, DBW_REG_RW_MASK)) begin
        s_nxt.rw_mask[k] = w;
      end else if (in_grp(i_ps_req.num, DBW_REG_RW_VAL)) begin
        s_nxt.rw_val[k] = w;
      end else if (in_grp(i_ps_req.num, DBW_REG_RW_CTRL)) begin
        s_nxt.rw_ctrl[k] = w & DBW_RW_WMASK;
      end
    end
    // a capture never meets a software write: writes need debug mode, captures need it off
    if (sel_cause != DBW_CAUSE_NONE && !i_in_debug) begin
      s_nxt.cause = sel_cause;
      s_nxt.idx   = sel_idx;
      s_nxt.thr   = sel_thr;
      s_nxt.irq   = 1'b1;
      if (sel_cause == DBW_CAUSE_DWATCH) begin
        s_nxt.data = i_mem.addr;
      end else if (sel_cause == DBW_CAUSE_RWATCH) begin
        s_nxt.data = i_res.id;
      end
    end
    // one cycle behind the mode input; the core must allow for it
    s_nxt.inhibit = s_nxt.halt & {8{!i_in_debug}};
    if (i_ps_req.rd) begin
      s_nxt.ps_rdata = rd_ps(s_r, i_ps_req.num);
    end
    if (i_cfg_req.rd) begin
      s_nxt.cfg_rdata = in_scr(i_cfg_req.num, DBW_CFG_SCR) ?
                        s_r.scr[i_cfg_req.num[2:0]] : DBW_RST_WORD;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_ps_rdata      = s_r.ps_rdata;
  assign o_cfg_rdata     = s_r.cfg_rdata;
  assign o_dbg_irq       = s_r.irq;
  assign o_halt_mask     = s_r.halt;
  assign o_issue_inhibit = s_r.inhibit;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  logic cap;
  assign cap = (sel_cause != DBW_CAUSE_NONE) && !i_in_debug;

  property p_host_cause;
    i_host_req && !i_in_debug |=> o_dbg_irq && s_r.cause == DBW_CAUSE_HOST && s_r.thr == 8'h00;
  endproperty
  a_host_cause: assert property (p_host_cause) else $error("host cause not recorded");

  property p_debug_call_instruction_idx;
    !i_host_req && i_debug_call_instruction && !i_in_debug |=> s_r.idx == 2'h0 && s_r.cause == DBW_CAUSE_DEBUG_CALL_INSTRUCTION;
  endproperty
  a_debug_call_instruction_idx: assert property (p_debug_call_instruction_idx) else $error("debug call index not zero");

  property p_lowest;
    cap && sel_cause == DBW_CAUSE_IBRK && ib_hit[2] && ib_hit[1:0] == 2'h0 |=> s_r.idx == 2'h2;
  endproperty
  a_lowest: assert property (p_lowest) else $error("lowest pc break not reported");

  property p_thread;
    cap && sel_cause == DBW_CAUSE_IBRK |=> s_r.thr == {5'h00, $past(i_pc.thread)};
  endproperty
  a_thread: assert property (p_thread) else $error("thread number wrong");

  property p_dw_data;
    cap && sel_cause == DBW_CAUSE_DWATCH |=> s_r.data == $past(i_mem.addr);
  endproperty
  a_dw_data: assert property (p_dw_data) else $error("watch address not captured");

  property p_rw_data;
    cap && sel_cause == DBW_CAUSE_RWATCH |=> s_r.data == $past(i_res.id);
  endproperty
  a_rw_data: assert property (p_rw_data) else $error("resource id not captured");

  property p_inhibit;
    ##1 !i_in_debug ##1 !i_in_debug |-> o_issue_inhibit == o_halt_mask;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("halted thread not inhibited");

  property p_no_write;
    !i_in_debug && i_ps_req.wr && i_ps_req.num == DBW_REG_HALT |=> $stable(o_halt_mask);
  endproperty
  a_no_write: assert property (p_no_write) else $error("write outside debug mode");

  property p_scr_shared;
    i_in_debug && i_ps_req.wr && in_scr(i_ps_req.num, DBW_REG_SCR) && !i_cfg_req.wr ##1
    !i_ps_req.wr && !i_cfg_req.wr ##1
    i_cfg_req.rd && i_cfg_req.num[2:0] == $past(i_ps_req.num[2:0], 2) &&
    in_scr(i_cfg_req.num, DBW_CFG_SCR) && !i_cfg_req.wr && !i_ps_req.wr
    |=> o_cfg_rdata == $past(i_ps_req.wdata, 3);
  endproperty
  a_scr_shared: assert property (p_scr_shared) else $error("scratch not shared");

  property p_reserved;
    ##1 i_ps_req.rd && in_grp(i_ps_req.num, DBW_REG_DW_CTRL)
    |=> (o_ps_rdata & ~DBW_DW_WMASK) == 32'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  property p_irq_pulse;
    o_dbg_irq |-> $past(cap);
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt without cause");

  property p_dbg_quiet;
    i_in_debug |=> !o_dbg_irq;
  endproperty
  a_dbg_quiet: assert property (p_dbg_quiet) else $error("irq in debug mode");

  property p_ib_data;
    cap && sel_cause == DBW_CAUSE_IBRK |=> $stable(s_r.data);
  endproperty
  a_ib_data: assert property (p_ib_data) else $error("data changed on pc break");

  property p_dw_thread;
    cap && sel_cause == DBW_CAUSE_DWATCH |=> s_r.thr == {5'h00, $past(i_mem.thread)};
  endproperty
  a_dw_thread: assert property (p_dw_thread) else $error("watch thread wrong");

  property p_rw_idx;
    cap && sel_cause == DBW_CAUSE_RWATCH && rw_hit[0] |=> s_r.idx == 2'h0 &&
    s_r.thr == {5'h00, $past(i_res.thread)};
  endproperty
  a_rw_idx: assert property (p_rw_idx) else $error("resource index wrong");

  c_host:  cover property (i_host_req && !i_in_debug ##1 o_dbg_irq);
  c_multi: cover property (cap && sel_cause == DBW_CAUSE_IBRK && ib_hit[1] && ib_hit[2]);
  c_dw:    cover property (cap && sel_cause == DBW_CAUSE_DWATCH && i_mem.is_load);
  c_rw:    cover property (cap && sel_cause == DBW_CAUSE_RWATCH);

endmodule

// File: sim/dbw_core_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// core side: enters debug mode on the interrupt, leaves on resume
// ----------------------------------------------------------------
module dbw_core_model (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // from the unit and the bench
  input  wire logic i_dbg_irq,
  input  wire logic i_resume,
  // to the unit
  output logic      o_in_debug
);
  // irq wins over resume so a late resume cannot lose a capture
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_in_debug <= 1'b0;
    end else if (i_dbg_irq) begin
      o_in_debug <= 1'b1;
    end else if (i_resume) begin
      o_in_debug <= 1'b0;
    end
  end
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) check(nm, e, g)

module tb_top;
  import dbw_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  typedef struct {string nm; int kind; logic [31:0] exp;} dbw_note_t;
  logic        i_clk;
  logic        i_rst_n;
  dbw_req_t    ps_req;
  dbw_req_t    cfg_req;
  logic        host_req;
  logic        debug_call_instruction;
  logic [2:0]  debug_call_instruction_thr;
  dbw_pc_t     pc;
  dbw_mem_t    mem;
  dbw_res_t    res;
  logic        resume;
  logic        in_debug;
  logic        dbg_irq;
  logic [31:0] ps_rdata;
  logic [31:0] cfg_rdata;
  logic [7:0]  halt_mask;
  logic [7:0]  inhibit;
  logic        ps_pend;
  logic        cfg_pend;
  int          n_errors;
  int          checked;
  int          seed;
  logic [31:0] va;
  logic [31:0] vb;
  logic [31:0] s0;
  dbw_note_t   notes[$];

  dbw_unit i_dbw_unit (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ps_req(ps_req), .o_ps_rdata(ps_rdata),
    .i_cfg_req(cfg_req), .o_cfg_rdata(cfg_rdata), .i_in_debug(in_debug),
    .i_host_req(host_req), .i_debug_call_instruction(debug_call_instruction), .i_debug_call_instruction_thread(debug_call_instruction_thr), .i_pc(pc),
    .i_mem(mem), .i_res(res), .o_dbg_irq(dbg_irq), .o_halt_mask(halt_mask),
    .o_issue_inhibit(inhibit));

  dbw_core_model i_dbw_core_model (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_dbg_irq(dbg_irq), .i_resume(resume),
    .o_in_debug(in_debug));

  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    // an expected event that never came is a mismatch too
    if (notes.size() != 0) n_errors++;
    $display("errors %0d of %0d checks", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // an event with no note waiting (e.g. a stray irq) is a mismatch
  task automatic take(input int k, input logic [31:0] g);
    dbw_note_t n;
    if (notes.size() == 0 || notes[0].kind != k) begin
      n_errors++;
      $display("wrong value event%0d expected none seen %h", k, g);
    end else begin
      n = notes.pop_front();
      `CHK(n.nm, n.exp, g);
    end
  endtask

  always @(posedge i_clk) begin
    ps_pend  <= ps_req.rd;
    cfg_pend <= cfg_req.rd;
  end

  always @(negedge i_clk) begin
    if (ps_pend) take(0, ps_rdata);
    if (cfg_pend) take(1, cfg_rdata);
    if (dbg_irq) take(2, 32'h1);
  end

  // ----------------------------------------------------------------
  // stimulus tasks
  // ----------------------------------------------------------------
  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask

  // p 0 status port, 1 config port; a read notes d as expected data
  task automatic acc(input int p, input bit w, input logic [7:0] a, input logic [31:0] d,
                     input string nm = "");
    dbw_req_t r;
    r = '{rd: !w, wr: w, num: a, wdata: w ? d : 32'h0};
    if (!w) notes.push_back('{nm, p, d});
    if (p == 0) ps_req = r;
    else cfg_req = r;
    tick();
    ps_req  = '0;
    cfg_req = '0;
    tick();
  endtask

  task automatic out(input bit r, input bit e);
    if (r) begin
      resume = 1'b1;
      tick();
      resume = 1'b0;
      tick();
    end
    if (e) notes.push_back('{"irq", 2, 32'h1});
  endtask

  // events stand for one cycle only, then wait for debug entry when e is set
  task automatic hit(input bit e);
    tick();
    pc       = '0;
    mem      = '0;
    res      = '0;
    host_req = 1'b0;
    debug_call_instruction    = 1'b0;
    for (int i = 0; i < 8 && e && !in_debug; i++) tick();
    // a trigger that must not fire would show as debug entry one cycle on
    if (!e) tick();
    `CHK("in_debug", {31'h0, e}, {31'h0, in_debug});
  endtask

  task automatic cause(input logic [31:0] e);
    acc(0, 0, DBW_REG_CAUSE, e, "cause");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  initial begin
    #(4000 * 25);
    n_errors++;
    final_report();
  end

  initial begin
    logic [7:0]  rg [3];
    logic [31:0] mk [3];
    seed = 94732;
    {ps_req, cfg_req, pc, mem, res} = '0;
    {host_req, debug_call_instruction, debug_call_instruction_thr, resume} = '0;
    i_rst_n = 1'b0;
    rg = '{DBW_REG_IB_CTRL, DBW_REG_DW_CTRL + 8'h2, DBW_REG_RW_CTRL + 8'h3};
    mk = '{32'h00FF0003, 32'h00FF0007, 32'h00FF0003};
    repeat (20) @(posedge i_clk);
    #1;
    i_rst_n = 1'b1;
    tick();
    cause(32'h0);
    acc(0, 0, DBW_REG_DW_CTRL + 8'h1, 32'h0, "dw ctrl reset");
    out(0, 1);
    host_req = 1'b1;
    hit(1);
    cause(32'h00000001);
    for (int k = 0; k < 3; k++) begin
      acc(0, 1, rg[k], 32'hFFFFFFFF);
      acc(0, 0, rg[k], mk[k], "ctrl mask");
      acc(0, 1, rg[k], 32'h0);
    end
    for (int k = 0; k < 8; k++) begin
      va = $random(seed);
      acc(0, 1, DBW_REG_SCR + k[7:0], va);
      acc(1, 0, DBW_CFG_SCR + k[7:0], va, "scratch cfg");
    end
    vb = $random(seed);
    acc(1, 1, DBW_CFG_SCR + 8'h7, vb);
    acc(0, 0, DBW_REG_SCR + 8'h7, vb, "scratch ps");
    s0 = $random(seed);
    acc(0, 1, DBW_REG_SCR, s0);
    acc(0, 1, DBW_REG_HALT, 32'hFFFFFFA5);
    acc(0, 0, DBW_REG_HALT, 32'h000000A5, "halt");
    `CHK("halt mask", 32'hA5, {24'h0, halt_mask});
    `CHK("inhibit in debug", 32'h0, {24'h0, inhibit});
    va = $random(seed);
    for (int k = 0; k < 4; k++) acc(0, 1, DBW_REG_IB_ADDR + k[7:0], va);
    acc(0, 1, DBW_REG_IB_CTRL, 32'h00000001);
    acc(0, 1, DBW_REG_IB_CTRL + 8'h2, 32'h00080001);
    acc(0, 1, DBW_REG_IB_CTRL + 8'h3, 32'h00080001);
    out(1, 1);
    `CHK("inhibit out", 32'hA5, {24'h0, inhibit});
    pc = '{1'b1, 3'h3, va};
    hit(1);
    cause(32'h00020303);
    acc(0, 1, DBW_REG_IB_CTRL + 8'h1, 32'h00020003);
    out(1, 0);
    pc = '{1'b1, 3'h1, va};
    hit(0);
    out(0, 1);
    pc = '{1'b1, 3'h1, va ^ 32'h4};
    hit(1);
    cause(32'h00010103);
    vb = $random(seed);
    acc(0, 1, DBW_REG_DW_A + 8'h1, va);
    acc(0, 1, DBW_REG_DW_B + 8'h1, vb);
    acc(0, 1, DBW_REG_DW_CTRL + 8'h1, 32'h00100001);
    out(1, 0);
    mem = '{1'b1, 1'b0, 3'h4, va};
    hit(0);
    acc(0, 1, DBW_REG_SCR, ~s0);
    acc(0, 1, DBW_REG_HALT, 32'h0);
    `CHK("halt kept", 32'hA5, {24'h0, halt_mask});
    out(0, 1);
    host_req = 1'b1;
    hit(1);
    cause(32'h00000001);
    acc(0, 1, DBW_REG_DW_CTRL + 8'h1, 32'h00100003);
    out(1, 1);
    mem = '{1'b1, 1'b0, 3'h4, vb};
    hit(1);
    cause(32'h00010404);
    acc(0, 0, DBW_REG_DATA, vb, "data");
    out(1, 0);
    mem = '{1'b1, 1'b1, 3'h4, vb};
    hit(0);
    out(0, 1);
    debug_call_instruction     = 1'b1;
    debug_call_instruction_thr = 3'h7;
    hit(1);
    cause(32'h00000702);
    acc(0, 1, DBW_REG_DW_CTRL + 8'h1, 32'h00100007);
    out(1, 1);
    mem = '{1'b1, 1'b1, 3'h4, va};
    hit(1);
    cause(32'h00010404);
    acc(0, 0, DBW_REG_DATA, va, "data load");
    va = {vb[31:8], 8'h2A};
    acc(0, 1, DBW_REG_RW_MASK, 32'h000000FF);
    acc(0, 1, DBW_REG_RW_VAL, 32'h0000002A);
    acc(0, 1, DBW_REG_RW_CTRL, 32'h00400001);
    out(1, 1);
    res = '{1'b1, 3'h6, va};
    hit(1);
    cause(32'h00000605);
    acc(0, 0, DBW_REG_DATA, va, "data res");
    // select bit set: the masked id must now differ from the value
    acc(0, 1, DBW_REG_RW_CTRL, 32'h00400003);
    out(1, 0);
    res = '{1'b1, 3'h6, va};
    hit(0);
    out(0, 1);
    res = '{1'b1, 3'h6, va ^ 32'h1};
    hit(1);
    cause(32'h00000605);
    acc(0, 0, DBW_REG_DATA, va ^ 32'h1, "data res b");
    acc(0, 0, DBW_REG_SCR, s0, "scratch kept");
    tick();
    final_report();
  end
endmodule
